// file: rtl/sosc_pkg.sv
// Shared constants, register map and state encodings of the sync output and standby block
package sosc_pkg;
   // -------------------------------------------------------------
   // Register offsets
   // -------------------------------------------------------------
   localparam logic [7:0] REG_SYNC_ACT = 8'h01;
   localparam logic [7:0] REG_SYNC_POL = 8'h02;
   localparam logic [7:0] REG_IN_CFG = 8'h05;
   localparam logic [7:0] REG_OUT_SYNC_CFG = 8'h18;
   localparam logic [7:0] REG_LP_WIDTH = 8'h19;
   localparam logic [7:0] REG_POWER = 8'h1B;
   localparam logic [7:0] REG_REF_MULT = 8'h2B;

   // -------------------------------------------------------------
   // Reset values (AC-coupled RGB, separate syncs, awake)
   // -------------------------------------------------------------
   localparam logic [7:0] RST_IN_CFG = 8'h00;
   localparam logic [7:0] RST_OUT_SYNC_CFG = 8'h80;
   localparam logic [7:0] RST_LP_WIDTH = 8'h20;
   localparam logic [7:0] RST_POWER = 8'h00;
   localparam logic [7:0] RST_REF_MULT = 8'h10;

   // -------------------------------------------------------------
   // Field positions and codes
   // -------------------------------------------------------------
   localparam int SOG_SEL_BIT = 4;
   localparam int LP_POL_BIT = 7;
   localparam int ACT_HS_BIT = 0;
   localparam int ACT_VS_BIT = 1;
   localparam int ACT_SOG_BIT = 2;
   localparam logic [7:0] STANDBY_CODE = 8'h0F;
   localparam logic [5:0] DEV_ADDR_HI = 6'h26;
   localparam logic [2:0] BIT_LAST = 3'h7;

   // -------------------------------------------------------------
   // Serial register port states
   // -------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK, ST_WDATA, ST_WDATA_ACK,
      ST_RDATA, ST_RDATA_WAIT, ST_RDATA_ACK, ST_RDATA_LOAD
   } sosc_ser_st_t;
endpackage

// file: rtl/sosc_line_if.sv
// Carrier between the register logic and the line pulse generator
interface sosc_line_if #(parameter int IDXW = 12);
   logic [7:0] width;
   logic active_high;
   logic enable;
   logic [IDXW-1:0] pixel_index;
   logic [IDXW-1:0] line_total;
   logic pulse;
   modport ctl (output width, active_high, enable, pixel_index, line_total, input pulse);
   modport gen (input width, active_high, enable, pixel_index, line_total, output pulse);
endinterface

// file: rtl/sosc_line_pulse.sv
// Pixel-aligned line pulse generator
module sosc_line_pulse #(parameter int IDXW = 12) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Control and pulse
   sosc_line_if.gen lif
);
   typedef struct packed {
      logic pulse;
   } sosc_lp_state_t;

   sosc_lp_state_t cur;
   sosc_lp_state_t nxt;
   logic [IDXW-1:0] win_start;
   logic width_ok;
   logic in_window;

   // --------------------------------------------------------------
   // Window ending on the last pixel, so the trailing edge hits pixel 0
   // --------------------------------------------------------------
   assign win_start = lif.line_total - IDXW'(lif.width);
   assign width_ok = (lif.width != 8'h00) && (IDXW'(lif.width) <= lif.line_total);
   assign in_window = lif.enable && width_ok && (lif.pixel_index >= win_start)
                      && (lif.pixel_index < lif.line_total);

   // Polarity applied last; wider pulse only moves the start earlier
   always_comb begin
      nxt = cur;
      nxt.pulse = ~(in_window ^ lif.active_high);
   end

   // Enable drops in standby, so the pulse simply rests inactive
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cur <= '{pulse: 1'b0};
      end else begin
         cur <= nxt;
      end
   end

   assign lif.pulse = cur.pulse;

   // --------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------
   sequence s_last_pixel;
      lif.enable && width_ok && (lif.pixel_index == lif.line_total - IDXW'(1));
   endsequence

   sequence s_window_start;
      lif.enable && width_ok && (lif.pixel_index == win_start);
   endsequence

   AST_LP_TRAIL: assert property (@(posedge clk) disable iff (!resetn)
      s_last_pixel |=> (lif.pulse == $past(lif.active_high)))
      else $error("line pulse not active on last pixel of line");
   AST_LP_LEAD: assert property (@(posedge clk) disable iff (!resetn)
      s_window_start |=> (lif.pulse == $past(lif.active_high)))
      else $error("line pulse leading edge misplaced");
   AST_LP_BEFORE: assert property (@(posedge clk) disable iff (!resetn)
      (lif.enable && width_ok && (win_start != '0) && (lif.pixel_index == win_start - IDXW'(1)))
      |=> (lif.pulse != $past(lif.active_high)))
      else $error("line pulse started too early");
   AST_LP_OFF: assert property (@(posedge clk) disable iff (!resetn)
      (!lif.enable) |=> (lif.pulse == !$past(lif.active_high)))
      else $error("line pulse not resting inactive");
endmodule

// file: rtl/sosc_top.sv
// Sync passthrough, line pulse, standby and serial register port of the video digitizer
// Summary of operation
// - Line sync output copies the selected line sync or embedded sync input.
// - Embedded sync selected: the whole embedded waveform goes to line sync output.
// - Separate syncs selected: frame sync output copies the frame sync input unchanged.
// - Embedded sync selected: frame sync output carries the slicer-extracted frame sync.
// - Copy-protection pulses lengthen or duplicate the extracted frame pulse, passed as given.
// - Both sync passthrough outputs keep running while powered down.
// - Line pulse runs on the pixel clock, trailing edge at pixel 0.
// - Line pulse lasts width register pixels; wider moves only the leading edge.
// - Bit 7 of output sync configuration picks the line pulse polarity.
// - Multiplier register scales the crystal to the internal reference; host picks it.
// - Writing 0x0F to power control enters standby, stopping converters and PLL.
// - Serial port, sync status registers and sync passthrough pins stay alive in standby; the line pulse rests inactive.
// - Power-on and external reset both restore every register default.
// - Register defaults set up an AC-coupled RGB input.
// - Register pointer increments after every data byte.
module sosc_top #(parameter int IDXW = 12) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Incoming syncs (asynchronous pins)
   input wire logic hsync_in,
   input wire logic vsync_in,
   input wire logic green_embedded_sync_in,
   input wire logic extracted_frame_sync_in,
   // Pixel timing from the output pipeline (same clock)
   input wire logic [IDXW-1:0] pixel_index,
   input wire logic [IDXW-1:0] line_total,
   // Serial register port
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic addr_sel_in,
   // Sync outputs
   output logic line_sync_out,
   output logic frame_sync_out,
   output logic pixel_aligned_line_pulse,
   // Power and reference control
   output logic standby_out,
   output logic analog_enable,
   output logic [7:0] ref_mult_out
);
   typedef struct packed {
      logic hs_s1;
      logic hs_s2;
      logic vs_s1;
      logic vs_s2;
      logic sog_s1;
      logic sog_s2;
      logic xvs_s1;
      logic xvs_s2;
      logic scl_s1;
      logic scl_s2;
      logic scl_s3;
      logic sda_s1;
      logic sda_s2;
      logic sda_s3;
      logic asel_s1;
      logic asel_s2;
      logic hs_d;
      logic vs_d;
      logic sog_d;
      logic line_out;
      logic frame_out;
      logic [2:0] act;
      logic [7:0] in_cfg;
      logic [7:0] out_cfg;
      logic [7:0] lp_width;
      logic [7:0] power;
      logic [7:0] ref_mult;
      logic standby;
      logic awake;
      sosc_pkg::sosc_ser_st_t st;
      logic [2:0] bitcnt;
      logic [7:0] shreg;
      logic rw;
      logic ack_on;
      logic [7:0] ptr;
      logic sda_drv;
   } sosc_state_t;

   localparam sosc_state_t RST_STATE = '{
      in_cfg: sosc_pkg::RST_IN_CFG,
      out_cfg: sosc_pkg::RST_OUT_SYNC_CFG,
      lp_width: sosc_pkg::RST_LP_WIDTH,
      power: sosc_pkg::RST_POWER,
      ref_mult: sosc_pkg::RST_REF_MULT,
      awake: 1'b1,
      st: sosc_pkg::ST_IDLE,
      scl_s1: 1'b1,
      scl_s2: 1'b1,
      scl_s3: 1'b1,
      sda_s1: 1'b1,
      sda_s2: 1'b1,
      sda_s3: 1'b1,
      default: '0
   };

   sosc_state_t cur;
   sosc_state_t nxt;

   // --------------------------------------------------------------
   // Register read decode
   // --------------------------------------------------------------
   function automatic logic [7:0] reg_read(input sosc_state_t s);
      case (s.ptr)
         sosc_pkg::REG_SYNC_ACT: reg_read = {5'h00, s.act};
         sosc_pkg::REG_SYNC_POL: reg_read = {5'h00, s.sog_s2, s.vs_s2, s.hs_s2};
         sosc_pkg::REG_IN_CFG: reg_read = s.in_cfg;
         sosc_pkg::REG_OUT_SYNC_CFG: reg_read = s.out_cfg;
         sosc_pkg::REG_LP_WIDTH: reg_read = s.lp_width;
         sosc_pkg::REG_POWER: reg_read = s.power;
         sosc_pkg::REG_REF_MULT: reg_read = s.ref_mult;
         default: reg_read = 8'h00;
      endcase
   endfunction

   // --------------------------------------------------------------
   // Serial bus events, taken from the second and third sync stages
   // --------------------------------------------------------------
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   logic [7:0] byte_c;
   logic [6:0] dev_addr;
   logic load_now;
   logic wr_now;
   logic rd_clr;
   logic sog_sel;

   assign scl_rise = cur.scl_s2 && !cur.scl_s3;
   assign scl_fall = !cur.scl_s2 && cur.scl_s3;
   assign start_c = cur.scl_s2 && cur.scl_s3 && !cur.sda_s2 && cur.sda_s3;
   assign stop_c = cur.scl_s2 && cur.scl_s3 && cur.sda_s2 && !cur.sda_s3;
   assign byte_c = {cur.shreg[6:0], cur.sda_s2};
   assign dev_addr = {sosc_pkg::DEV_ADDR_HI, cur.asel_s2};
   assign wr_now = !start_c && !stop_c && scl_rise && (cur.st == sosc_pkg::ST_WDATA)
                   && (cur.bitcnt == sosc_pkg::BIT_LAST);
   assign load_now = !start_c && !stop_c && scl_fall
                     && (((cur.st == sosc_pkg::ST_ADDR_ACK) && cur.ack_on && cur.rw)
                         || (cur.st == sosc_pkg::ST_RDATA_LOAD));
   assign rd_clr = load_now && (cur.ptr == sosc_pkg::REG_SYNC_ACT);
   assign sog_sel = cur.in_cfg[sosc_pkg::SOG_SEL_BIT];

   // --------------------------------------------------------------
   // Line pulse generator
   // --------------------------------------------------------------
   sosc_line_if #(.IDXW(IDXW)) lif ();

   assign lif.width = cur.lp_width;
   assign lif.active_high = cur.out_cfg[sosc_pkg::LP_POL_BIT];
   assign lif.enable = cur.awake;
   assign lif.pixel_index = pixel_index;
   assign lif.line_total = line_total;

   sosc_line_pulse #(.IDXW(IDXW)) u_line_pulse (
      .clk(clk),
      .resetn(resetn),
      .lif(lif)
   );

   // Next state of the whole block
   always_comb begin
      nxt = cur;
      // Synchronisers: first stage feeds only the second
      nxt.hs_s1 = hsync_in;
      nxt.hs_s2 = cur.hs_s1;
      nxt.vs_s1 = vsync_in;
      nxt.vs_s2 = cur.vs_s1;
      nxt.sog_s1 = green_embedded_sync_in;
      nxt.sog_s2 = cur.sog_s1;
      nxt.xvs_s1 = extracted_frame_sync_in;
      nxt.xvs_s2 = cur.xvs_s1;
      nxt.scl_s1 = scl_in;
      nxt.scl_s2 = cur.scl_s1;
      nxt.scl_s3 = cur.scl_s2;
      nxt.sda_s1 = sda_in;
      nxt.sda_s2 = cur.sda_s1;
      nxt.sda_s3 = cur.sda_s2;
      nxt.asel_s1 = addr_sel_in;
      nxt.asel_s2 = cur.asel_s1;
      nxt.hs_d = cur.hs_s2;
      nxt.vs_d = cur.vs_s2;
      nxt.sog_d = cur.sog_s2;

      // Passthrough ignores standby so mode detection works powered down
      nxt.line_out = sog_sel ? cur.sog_s2 : cur.hs_s2;
      nxt.frame_out = sog_sel ? cur.xvs_s2 : cur.vs_s2;

      // Activity flags: an edge in the read cycle survives the clear
      nxt.act = (rd_clr ? 3'h0 : cur.act)
                | {cur.sog_s2 ^ cur.sog_d, cur.vs_s2 ^ cur.vs_d, cur.hs_s2 ^ cur.hs_d};

      // Only the exact code enters standby; any other value wakes
      nxt.standby = (cur.power == sosc_pkg::STANDBY_CODE);
      nxt.awake = (cur.power != sosc_pkg::STANDBY_CODE);

      // Serial port keeps running in standby for register access
      if (stop_c) begin
         nxt.st = sosc_pkg::ST_IDLE;
         nxt.sda_drv = 1'b0;
         nxt.ack_on = 1'b0;
      end else if (start_c) begin
         nxt.st = sosc_pkg::ST_ADDR;
         nxt.bitcnt = 3'h0;
         nxt.sda_drv = 1'b0;
         nxt.ack_on = 1'b0;
      end else begin
         case (cur.st)
            sosc_pkg::ST_ADDR, sosc_pkg::ST_PTR, sosc_pkg::ST_WDATA: begin
               if (scl_rise) begin
                  nxt.shreg = byte_c;
                  nxt.bitcnt = cur.bitcnt + 3'h1;
                  if (cur.bitcnt == sosc_pkg::BIT_LAST) begin
                     if (cur.st == sosc_pkg::ST_ADDR) begin
                        nxt.rw = byte_c[0];
                        nxt.st = (byte_c[7:1] == dev_addr) ? sosc_pkg::ST_ADDR_ACK : sosc_pkg::ST_IDLE;
                     end else if (cur.st == sosc_pkg::ST_PTR) begin
                        nxt.ptr = byte_c;
                        nxt.st = sosc_pkg::ST_PTR_ACK;
                     end else begin
                        nxt.ptr = cur.ptr + 8'h01;
                        nxt.st = sosc_pkg::ST_WDATA_ACK;
                     end
                  end
               end
            end
            sosc_pkg::ST_ADDR_ACK, sosc_pkg::ST_PTR_ACK, sosc_pkg::ST_WDATA_ACK: begin
               if (scl_fall) begin
                  nxt.ack_on = !cur.ack_on;
                  nxt.sda_drv = !cur.ack_on;
                  nxt.bitcnt = 3'h0;
                  if (cur.ack_on) begin
                     nxt.st = (cur.st == sosc_pkg::ST_ADDR_ACK) ? sosc_pkg::ST_PTR : sosc_pkg::ST_WDATA;
                  end
               end
            end
            sosc_pkg::ST_RDATA: begin
               if (scl_rise) begin
                  nxt.bitcnt = cur.bitcnt + 3'h1;
                  if (cur.bitcnt == sosc_pkg::BIT_LAST) begin
                     nxt.st = sosc_pkg::ST_RDATA_WAIT;
                  end
               end else if (scl_fall) begin
                  nxt.shreg = {cur.shreg[6:0], 1'b0};
                  nxt.sda_drv = !cur.shreg[6];
               end
            end
            sosc_pkg::ST_RDATA_WAIT: begin
               if (scl_fall) begin
                  nxt.sda_drv = 1'b0;
                  nxt.st = sosc_pkg::ST_RDATA_ACK;
               end
            end
            sosc_pkg::ST_RDATA_ACK: begin
               if (scl_rise) begin
                  nxt.st = cur.sda_s2 ? sosc_pkg::ST_IDLE : sosc_pkg::ST_RDATA_LOAD;
               end
            end
            sosc_pkg::ST_RDATA_LOAD: begin
               nxt.st = sosc_pkg::ST_RDATA_LOAD;
            end
            sosc_pkg::ST_IDLE: begin
               nxt.st = sosc_pkg::ST_IDLE;
            end
            default: begin
               nxt.st = sosc_pkg::ST_IDLE;
            end
         endcase
      end

      // Read byte load, shared by the first and each following byte
      if (load_now) begin
         nxt.shreg = reg_read(cur);
         nxt.sda_drv = !nxt.shreg[7];
         nxt.ptr = cur.ptr + 8'h01;
         nxt.bitcnt = 3'h0;
         nxt.ack_on = 1'b0;
         nxt.st = sosc_pkg::ST_RDATA;
      end

      // Register writes; status registers are read only
      if (wr_now) begin
         case (cur.ptr)
            sosc_pkg::REG_IN_CFG: nxt.in_cfg = byte_c;
            sosc_pkg::REG_OUT_SYNC_CFG: nxt.out_cfg = byte_c;
            sosc_pkg::REG_LP_WIDTH: nxt.lp_width = byte_c;
            sosc_pkg::REG_POWER: nxt.power = byte_c;
            sosc_pkg::REG_REF_MULT: nxt.ref_mult = byte_c;
            default: nxt.power = cur.power;
         endcase
      end
   end

   // One reset path for power-on and the active-low pin
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cur <= RST_STATE;
      end else begin
         cur <= nxt;
      end
   end

   // --------------------------------------------------------------
   // Outputs, all straight from state flops
   // --------------------------------------------------------------
   assign sda_out = 1'b0 & cur.sda_drv;
   assign sda_oe = cur.sda_drv;
   assign line_sync_out = cur.line_out;
   assign frame_sync_out = cur.frame_out;
   assign pixel_aligned_line_pulse = lif.pulse; // Generator flop; one more stage would end the pulse on pixel 1
   assign standby_out = cur.standby;
   assign analog_enable = cur.awake;
   assign ref_mult_out = cur.ref_mult;

   // --------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------
   sequence s_write_to(logic [7:0] a);
      wr_now && (cur.ptr == a);
   endsequence

   AST_LINE_HS: assert property (@(posedge clk) disable iff (!resetn)
      (!sog_sel) |=> (line_sync_out == $past(cur.hs_s2)))
      else $error("line sync output not following line sync input");
   AST_LINE_SOG: assert property (@(posedge clk) disable iff (!resetn)
      sog_sel |=> (line_sync_out == $past(cur.sog_s2)))
      else $error("line sync output not following embedded sync");
   AST_FRAME_VS: assert property (@(posedge clk) disable iff (!resetn)
      (!sog_sel) |=> (frame_sync_out == $past(cur.vs_s2)))
      else $error("frame sync output not following frame sync input");
   AST_FRAME_XVS: assert property (@(posedge clk) disable iff (!resetn)
      sog_sel |=> (frame_sync_out == $past(cur.xvs_s2)))
      else $error("frame sync output not following extracted frame sync");
   AST_STBY_SYNC: assert property (@(posedge clk) disable iff (!resetn)
      (cur.standby && !sog_sel) ##1 (cur.hs_s2 != cur.hs_d) |=> (line_sync_out == cur.hs_d))
      else $error("sync passthrough stalled in standby");
   AST_STBY_ENTER: assert property (@(posedge clk) disable iff (!resetn)
      s_write_to(sosc_pkg::REG_POWER) ##0 (byte_c == sosc_pkg::STANDBY_CODE)
      |=> ##1 (standby_out && !analog_enable && !lif.enable))
      else $error("standby code did not enter standby");
   AST_STBY_ACT: assert property (@(posedge clk) disable iff (!resetn)
      (cur.standby && (cur.hs_s2 != cur.hs_d)) |=> cur.act[sosc_pkg::ACT_HS_BIT])
      else $error("activity flag lost in standby or to a clear");
   AST_REF_MULT: assert property (@(posedge clk) disable iff (!resetn)
      s_write_to(sosc_pkg::REG_REF_MULT) |=> (ref_mult_out == $past(byte_c)))
      else $error("multiplier write not seen at output");
   AST_RST_DEF: assert property (@(posedge clk) disable iff (!resetn)
      $rose(resetn) |-> ((cur.power == sosc_pkg::RST_POWER) && (cur.in_cfg == sosc_pkg::RST_IN_CFG)
                         && (cur.lp_width == sosc_pkg::RST_LP_WIDTH) && !standby_out))
      else $error("register not at default after reset");
   AST_PTR_INC: assert property (@(posedge clk) disable iff (!resetn)
      (wr_now || load_now) |=> (cur.ptr == $past(cur.ptr) + 8'h01))
      else $error("register pointer did not advance");
endmodule

// file: verification/sosc_scaler_model.sv
// Downstream scaler model: measures the line pulse against the pixel bus
module sosc_scaler_model #(parameter int IDXW = 12) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Pixel timing and line pulse from the digitizer
   input wire logic [IDXW-1:0] pixel_index,
   input wire logic pulse,
   input wire logic active_high,
   // Last pulse seen
   output logic [7:0] last_width,
   output logic [IDXW-1:0] last_pixel
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [IDXW-1:0] bus_pixel_ff;
   logic [7:0] run_ff;
   logic active;
   // -------------------------------------------------------------
   // Pulse measurement
   // -------------------------------------------------------------
   assign active = (pulse === active_high);
   // Pixel data trails the index by one cycle, so the bus shows last cycle's index
   always @(posedge clk) begin
      if (!resetn) begin
         bus_pixel_ff <= '0;
         run_ff <= 8'h00;
         last_width <= 8'h00;
         last_pixel <= '1;
      end else begin
         bus_pixel_ff <= pixel_index;
         if (active) begin
            run_ff <= run_ff + 8'h01;
         end else if (run_ff != 8'h00) begin
            last_width <= run_ff;
            last_pixel <= bus_pixel_ff;
            run_ff <= 8'h00;
         end
      end
   end
endmodule

// file: verification/tb_sosc_top.sv
// Self-checking bench of the sync output and standby block
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
$display("Error at %0t: got %0h expected %0h", $time, g, e); end end
module tb_sosc_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int IDXW = 12;
   localparam logic [IDXW-1:0] LINE_LEN = 12'h0010;
   localparam int LIMIT = 90000;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic hsync_in = 1'b0;
   logic vsync_in = 1'b0;
   logic ges_in = 1'b0;
   logic efs_in = 1'b0;
   logic [IDXW-1:0] pixel_index = '0;
   logic scl = 1'b1;
   logic sda_m = 1'b1;
   logic sda_in, sda_out, sda_oe, ack, pol_exp;
   logic line_sync_out, frame_sync_out, pixel_aligned_line_pulse, standby_out, analog_enable;
   logic [7:0] ref_mult_out, last_width;
   logic [IDXW-1:0] last_pixel;
   logic [31:0] v;
   int fail_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   // -------------------------------------------------------------
   // Clock, open-drain wire, pixel counter and hang guard
   // -------------------------------------------------------------
   always #2 clk = ~clk;
   assign sda_in = sda_m & (sda_oe ? sda_out : 1'b1);
   always @(negedge clk) begin
      pixel_index <= (pixel_index == LINE_LEN - 1) ? '0 : pixel_index + 1'b1;
   end
   // A hung handshake must still end in the verdict
   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         fail_count++;
         finish_test();
      end
   end
   sosc_top #(.IDXW(IDXW)) i_sosc_top (.clk(clk), .resetn(resetn), .hsync_in(hsync_in), .vsync_in(vsync_in),
      .green_embedded_sync_in(ges_in), .extracted_frame_sync_in(efs_in), .pixel_index(pixel_index),
      .line_total(LINE_LEN), .scl_in(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
      .addr_sel_in(1'b0), .line_sync_out(line_sync_out), .frame_sync_out(frame_sync_out),
      .pixel_aligned_line_pulse(pixel_aligned_line_pulse), .standby_out(standby_out),
      .analog_enable(analog_enable), .ref_mult_out(ref_mult_out));
   sosc_scaler_model #(.IDXW(IDXW)) i_sosc_scaler_model (.clk(clk), .resetn(resetn), .pixel_index(pixel_index),
      .pulse(pixel_aligned_line_pulse), .active_high(pol_exp), .last_width(last_width), .last_pixel(last_pixel));
   // -------------------------------------------------------------
   // Serial port tasks: slow enough for the three-clock synchronisers
   // -------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic sbit(input logic b, output logic r);
      tick(4);
      sda_m = b;
      tick(4);
      scl = 1'b1;
      tick(8);
      r = sda_in;
      scl = 1'b0;
   endtask
   task automatic start();
      sda_m = 1'b1;
      tick(6);
      scl = 1'b1;
      tick(8);
      sda_m = 1'b0;
      tick(8);
      scl = 1'b0;
   endtask
   task automatic stop();
      tick(4);
      sda_m = 1'b0;
      tick(4);
      scl = 1'b1;
      tick(8);
      sda_m = 1'b1;
      tick(8);
   endtask
   task automatic sbyte(input logic [7:0] d, input logic nine, output logic [7:0] q);
      for (int i = 7; i >= 0; i--) begin
         sbit(d[i], q[i]);
      end
      sbit(nine, ack);
   endtask
   task automatic wr(input logic [7:0] ptr, input logic [15:0] d, input int n);
      logic [7:0] q;
      start();
      sbyte({sosc_pkg::DEV_ADDR_HI, 2'b00}, 1'b1, q);
      `CHK(ack, 1'b0)
      sbyte(ptr, 1'b1, q);
      for (int i = n - 1; i >= 0; i--) begin
         sbyte(d[8*i +: 8], 1'b1, q);
      end
      stop();
   endtask
   task automatic rd(input logic [7:0] ptr, input int n, output logic [31:0] r);
      logic [7:0] q;
      r = '0;
      start();
      sbyte({sosc_pkg::DEV_ADDR_HI, 2'b00}, 1'b1, q);
      sbyte(ptr, 1'b1, q);
      start();
      sbyte({sosc_pkg::DEV_ADDR_HI, 2'b01}, 1'b1, q);
      for (int i = n - 1; i >= 0; i--) begin
         sbyte(8'hFF, (i == 0), q);
         r[8*i +: 8] = q;
      end
      stop();
   endtask
   // -------------------------------------------------------------
   // Scenario helpers
   // -------------------------------------------------------------
   task automatic pass(input logic sel, input logic [3:0] p);
      {hsync_in, vsync_in, ges_in, efs_in} = p;
      tick(4);
      `CHK(line_sync_out, sel ? p[1] : p[3])
      `CHK(frame_sync_out, sel ? p[0] : p[2])
   endtask
   // Widths alternate so a stale measurement never matches
   task automatic lp(input logic pol, input logic [7:0] w);
      wr(sosc_pkg::REG_OUT_SYNC_CFG, {pol, 7'h00, w}, 2);
      pol_exp = pol;
      tick(3 * 16);
      `CHK(last_width, w)
      `CHK(last_pixel, 12'h000)
   endtask
   task automatic finish_test();
      if (fail_count == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      pol_exp = 1'b1;
      tick(6);
      resetn = 1'b1;
      tick(4);
      `CHK(ref_mult_out, sosc_pkg::RST_REF_MULT)
      `CHK(analog_enable, 1'b1)
      rd(sosc_pkg::REG_OUT_SYNC_CFG, 4, v);
      `CHK(v, {sosc_pkg::RST_OUT_SYNC_CFG, sosc_pkg::RST_LP_WIDTH, 8'h00, sosc_pkg::RST_POWER})
      wr(sosc_pkg::REG_REF_MULT, 16'h000C, 1);
      `CHK(ref_mult_out, 8'h0C)
      lp(1'b1, 8'h01);
      lp(1'b1, 8'h05);
      lp(1'b0, 8'h02);
      lp(1'b0, 8'h0F);
      for (int s = 0; s < 2; s++) begin
         wr(sosc_pkg::REG_IN_CFG, {11'h000, s[0], 4'h0}, 1);
         for (int p = 0; p < 16; p++) begin
            pass(s[0], p[3:0]);
         end
      end
      wr(sosc_pkg::REG_POWER, {8'h00, sosc_pkg::STANDBY_CODE}, 1);
      `CHK({standby_out, analog_enable}, 2'b10)
      for (int s = 1; s >= 0; s--) begin
         wr(sosc_pkg::REG_IN_CFG, {11'h000, s[0], 4'h0}, 1);
         for (int p = 15; p >= 0; p--) begin
            pass(s[0], p[3:0]);
         end
      end
      {hsync_in, vsync_in, ges_in, efs_in} = 4'b1010;
      rd(sosc_pkg::REG_SYNC_ACT, 2, v);
      `CHK(v[15:0], 16'h0705)
      rd(sosc_pkg::REG_SYNC_ACT, 1, v);
      `CHK(v[7:0], 8'h00)
      rd(sosc_pkg::REG_POWER, 1, v);
      `CHK(v[7:0], sosc_pkg::STANDBY_CODE)
      wr(sosc_pkg::REG_POWER, 16'h0000, 1);
      `CHK({standby_out, analog_enable}, 2'b01)
      wr(sosc_pkg::REG_POWER, {8'h00, sosc_pkg::STANDBY_CODE}, 1);
      resetn = 1'b0;
      tick(2);
      resetn = 1'b1;
      tick(4);
      `CHK({standby_out, ref_mult_out}, {1'b0, sosc_pkg::RST_REF_MULT})
      rd(sosc_pkg::REG_IN_CFG, 1, v);
      `CHK(v[7:0], sosc_pkg::RST_IN_CFG)
      finish_test();
   end
endmodule
